// >>> logic/output_sync_pkg.sv
// constants for the output synchronisation parameter block
package output_sync_pkg;

    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register byte addresses
    localparam logic [7:0] OFS_ENTRY_COUNT = 8'h00;
    localparam logic [7:0] OFS_MODE_SELECT = 8'h04;
    localparam logic [7:0] OFS_CYCLE_NS    = 8'h08;
    localparam logic [7:0] OFS_PULSE0_DRV  = 8'h0C;
    localparam logic [7:0] OFS_SUPPORTED   = 8'h10;
    localparam logic [7:0] OFS_MIN_PERIOD  = 8'h14;
    localparam logic [7:0] OFS_GAP_MIN     = 8'h18;
    localparam logic [7:0] OFS_COMMAND     = 8'h1C;
    localparam logic [7:0] OFS_PULSE1_DRV  = 8'h20;
    localparam logic [7:0] OFS_MISSED      = 8'h24;
    localparam logic [7:0] OFS_OVERRUN     = 8'h28;
    localparam logic [7:0] OFS_GAP_SHORT   = 8'h2C;
    localparam logic [7:0] OFS_LATE        = 8'h30;
    localparam logic [7:0] OFS_IRQ_STATUS  = 8'h34;
    localparam logic [7:0] OFS_IRQ_MASK    = 8'h38;

    // reset values and constants
    localparam logic [7:0]  ENTRY_COUNT    = 8'h20;
    localparam logic [15:0] MODE_FREE_RUN  = 16'h0000;
    localparam logic [15:0] MODE_MANAGER   = 16'h0001;
    localparam logic [15:0] MODE_PULSE0    = 16'h0002;
    localparam logic [15:0] MODE_PULSE1    = 16'h0003;
    localparam logic [31:0] CYCLE_NS_RST   = 32'h0007_A120;
    localparam logic [15:0] SUPPORTED_MASK = 16'hC007;
    localparam logic [31:0] MIN_PERIOD_RST = 32'h0000_4E20;
    localparam logic [15:0] CMD_STOP       = 16'h0000;
    localparam logic [15:0] CMD_START      = 16'h0001;
    localparam logic [15:0] COUNT_MAX      = 16'hFFFF;
    localparam logic [31:0] NS_MAX         = 32'hFFFF_FFFF;

    // interrupt status / mask bit positions
    localparam int IRQ_W       = 4;
    localparam int IRQ_MISSED  = 0;
    localparam int IRQ_OVERRUN = 1;
    localparam int IRQ_SHORT   = 2;
    localparam int IRQ_LATE    = 3;

    // clock: 20 MHz
    localparam int CLK_PERIOD_NS = 50;
    localparam logic [31:0] NS_PER_CLK = 32'(CLK_PERIOD_NS);

endpackage

// >>> logic/output_sync_params.sv
// output synchronisation parameter bank with timing measurement and counters
`timescale 1ns/1ps
module output_sync_params (
    input  wire logic        clk_sys,        // 20 MHz system clock
    input  wire logic        rst_n,          // synchronous reset, active low
    input  wire logic        clk_en,         // low freezes all state
    input  wire logic [7:0]  avs_address,    // byte address
    input  wire logic        avs_read,       // read request
    input  wire logic        avs_write,      // write request
    input  wire logic [31:0] avs_writedata,  // write data
    input  wire logic [3:0]  avs_byteenable, // byte lanes of a write
    output logic      [31:0] avs_readdata,   // read data
    output logic             avs_waitrequest,// stall while high
    input  wire logic        pulse0_pin,     // distributed-clock pulse 0
    input  wire logic        pulse1_pin,     // distributed-clock pulse 1
    input  wire logic        manager_event,  // output manager event, async
    input  wire logic        operational,    // device in operational state
    input  wire logic        outputs_done,   // pulse: outputs were driven
    output logic             apply_outputs,  // pulse: start of output cycle
    output logic             measure_active, // measurement runs
    output logic             irq             // level interrupt
);

    ////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [2:0]  p0_sync;
        logic [2:0]  p1_sync;
        logic [2:0]  ev_sync;
        logic [15:0] mode;
        logic [31:0] cycle_ns;
        logic [15:0] command;
        logic [31:0] pulse0_drv;
        logic [31:0] min_period;
        logic [31:0] gap_min;
        logic [31:0] pulse1_drv;
        logic [15:0] missed;
        logic [15:0] overrun;
        logic [15:0] gap_short;
        logic        late;
        logic [3:0]  irq_status;
        logic [3:0]  irq_mask;
        logic [31:0] since0;
        logic [31:0] since1;
        logic [31:0] since_start;
        logic [31:0] timer_ns;
        logic        busy;
        logic        event_seen;
        logic        ack;
        logic [31:0] rdata;
        logic        apply;
    } state_type;

    state_type st_ff;
    state_type nxt_st;

    function automatic logic [31:0] sat_add_ns(input logic [31:0] a);
        logic [32:0] s;
        s = {1'b0, a} + {1'b0, output_sync_pkg::NS_PER_CLK};
        sat_add_ns = s[32] ? output_sync_pkg::NS_MAX : s[31:0];
    endfunction

    function automatic logic [15:0] sat_inc(input logic [15:0] a);
        sat_inc = (a == output_sync_pkg::COUNT_MAX) ? a : a + 16'h0001;
    endfunction

    function automatic logic [31:0] max_ns(input logic [31:0] a,
                                           input logic [31:0] b);
        max_ns = (a > b) ? a : b;
    endfunction

    function automatic logic [31:0] merge_be(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        merge_be = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // combinational decode of the current state
    logic        edge0;
    logic        edge1;
    logic        edge_ev;
    logic        dc_mode;
    logic        timer_fire;
    logic        cycle_start;
    logic        bus_req;
    logic        wr_take;
    logic        start_meas;
    logic [31:0] wr_val;
    logic [31:0] rd_mux;
    logic [31:0] timer_next;
    logic [3:0]  irq_events;

    assign edge0   = st_ff.p0_sync[1] & ~st_ff.p0_sync[2];
    assign edge1   = st_ff.p1_sync[1] & ~st_ff.p1_sync[2];
    assign edge_ev = st_ff.ev_sync[1] & ~st_ff.ev_sync[2];
    assign dc_mode = (st_ff.mode == output_sync_pkg::MODE_PULSE0) ||
                     (st_ff.mode == output_sync_pkg::MODE_PULSE1);
    assign timer_next = sat_add_ns(st_ff.timer_ns);
    assign timer_fire = (st_ff.mode == output_sync_pkg::MODE_FREE_RUN) &&
                        (timer_next >= st_ff.cycle_ns);

    always_comb begin
        case (st_ff.mode)
            output_sync_pkg::MODE_FREE_RUN: cycle_start = timer_fire;
            output_sync_pkg::MODE_MANAGER:  cycle_start = edge_ev;
            output_sync_pkg::MODE_PULSE0:   cycle_start = edge0;
            output_sync_pkg::MODE_PULSE1:   cycle_start = edge1;
            default:                        cycle_start = 1'b0;
        endcase
    end

    // one wait cycle, then the answer: waitrequest drops with st_ff.ack high
    assign bus_req         = avs_read | avs_write;
    assign avs_waitrequest = bus_req & ~st_ff.ack;
    assign wr_take    = clk_en & avs_write & st_ff.ack;
    assign wr_val     = avs_writedata;
    assign start_meas = wr_take &&
                        (avs_address == output_sync_pkg::OFS_COMMAND) &&
                        avs_byteenable[0] &&
                        (merge_be({16'h0000, st_ff.command}, wr_val,
                                  avs_byteenable) ==
                         {16'h0000, output_sync_pkg::CMD_START}) &&
                        (st_ff.command != output_sync_pkg::CMD_START);

    always_comb begin
        case (avs_address)
            output_sync_pkg::OFS_ENTRY_COUNT:
                rd_mux = {24'h00_0000, output_sync_pkg::ENTRY_COUNT};
            output_sync_pkg::OFS_MODE_SELECT: rd_mux = {16'h0000, st_ff.mode};
            output_sync_pkg::OFS_CYCLE_NS:    rd_mux = st_ff.cycle_ns;
            output_sync_pkg::OFS_PULSE0_DRV:  rd_mux = st_ff.pulse0_drv;
            output_sync_pkg::OFS_SUPPORTED:
                rd_mux = {16'h0000, output_sync_pkg::SUPPORTED_MASK};
            output_sync_pkg::OFS_MIN_PERIOD:  rd_mux = st_ff.min_period;
            output_sync_pkg::OFS_GAP_MIN:     rd_mux = st_ff.gap_min;
            output_sync_pkg::OFS_COMMAND:
                rd_mux = {16'h0000, st_ff.command};
            output_sync_pkg::OFS_PULSE1_DRV:  rd_mux = st_ff.pulse1_drv;
            output_sync_pkg::OFS_MISSED:      rd_mux = {16'h0000, st_ff.missed};
            output_sync_pkg::OFS_OVERRUN:
                rd_mux = {16'h0000, st_ff.overrun};
            output_sync_pkg::OFS_GAP_SHORT:
                rd_mux = {16'h0000, st_ff.gap_short};
            output_sync_pkg::OFS_LATE:        rd_mux = {31'h0, st_ff.late};
            output_sync_pkg::OFS_IRQ_STATUS:
                rd_mux = {28'h0, st_ff.irq_status};
            output_sync_pkg::OFS_IRQ_MASK:    rd_mux = {28'h0, st_ff.irq_mask};
            default:                          rd_mux = 32'h0000_0000;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        nxt_st = st_ff;
        irq_events = 4'h0;
        if (clk_en) begin
            // pins: two flops, then an edge-detect flop
            nxt_st.p0_sync = {st_ff.p0_sync[1:0], pulse0_pin};
            nxt_st.p1_sync = {st_ff.p1_sync[1:0], pulse1_pin};
            nxt_st.ev_sync = {st_ff.ev_sync[1:0], manager_event};

            // bus slave
            nxt_st.ack = bus_req & ~st_ff.ack;
            if (bus_req && !st_ff.ack) begin
                nxt_st.rdata = rd_mux;
            end

            // elapsed-time trackers in ns
            nxt_st.since0 = edge0 ? 32'h0000_0000 : sat_add_ns(st_ff.since0);
            nxt_st.since1 = edge1 ? 32'h0000_0000 : sat_add_ns(st_ff.since1);
            nxt_st.since_start = cycle_start ? 32'h0000_0000
                                             : sat_add_ns(st_ff.since_start);
            // local timer period follows the cycle register in free run
            nxt_st.timer_ns = (timer_fire ||
                (st_ff.mode != output_sync_pkg::MODE_FREE_RUN)) ?
                32'h0000_0000 : timer_next;

            nxt_st.apply = cycle_start;
            // a new cycle wins over the completion of the previous one
            nxt_st.busy = cycle_start | (st_ff.busy & ~outputs_done);
            // event arriving with the cycle start still counts as seen
            nxt_st.event_seen = edge_ev | (st_ff.event_seen & ~cycle_start);

            if (cycle_start && operational && st_ff.busy) begin
                nxt_st.overrun = sat_inc(st_ff.overrun);
                irq_events[output_sync_pkg::IRQ_OVERRUN] = 1'b1;
            end
            if (cycle_start && operational && dc_mode &&
                !st_ff.event_seen && !edge_ev) begin
                nxt_st.missed = sat_inc(st_ff.missed);
                irq_events[output_sync_pkg::IRQ_MISSED] = 1'b1;
            end
            if (edge1 && dc_mode && (st_ff.since0 < st_ff.gap_min)) begin
                nxt_st.gap_short = sat_inc(st_ff.gap_short);
                irq_events[output_sync_pkg::IRQ_SHORT] = 1'b1;
            end
            if (cycle_start && dc_mode) begin
                // previous outputs still pending when the next cycle begins
                nxt_st.late = st_ff.busy;
                irq_events[output_sync_pkg::IRQ_LATE] = st_ff.busy;
            end

            // maxima while measuring
            if (st_ff.command == output_sync_pkg::CMD_START) begin
                if (outputs_done && st_ff.busy) begin
                    nxt_st.min_period = max_ns(st_ff.min_period,
                                               st_ff.since_start);
                    if (dc_mode) begin
                        nxt_st.pulse0_drv = max_ns(st_ff.pulse0_drv,
                                                   st_ff.since0);
                        nxt_st.pulse1_drv = max_ns(st_ff.pulse1_drv,
                                                   st_ff.since1);
                    end
                end
                if (edge1 && dc_mode) begin
                    nxt_st.gap_min = max_ns(st_ff.gap_min,
                                            st_ff.since0);
                end
            end
            if (start_meas) begin
                nxt_st.pulse0_drv = 32'h0000_0000;
                nxt_st.pulse1_drv = 32'h0000_0000;
                nxt_st.min_period = 32'h0000_0000;
                nxt_st.gap_min    = 32'h0000_0000;
            end

            // register writes
            if (wr_take) begin
                case (avs_address)
                    output_sync_pkg::OFS_MODE_SELECT: begin
                        nxt_st.mode = 16'(merge_be({16'h0000, st_ff.mode},
                                      wr_val, avs_byteenable));
                    end
                    output_sync_pkg::OFS_CYCLE_NS: begin
                        nxt_st.cycle_ns = merge_be(st_ff.cycle_ns, wr_val,
                                                   avs_byteenable);
                    end
                    output_sync_pkg::OFS_COMMAND: begin
                        nxt_st.command = 16'(merge_be({16'h0000,
                                         st_ff.command}, wr_val,
                                         avs_byteenable));
                    end
                    output_sync_pkg::OFS_IRQ_MASK: begin
                        if (avs_byteenable[0]) begin
                            nxt_st.irq_mask = wr_val[3:0];
                        end
                    end
                    output_sync_pkg::OFS_IRQ_STATUS: begin
                        if (avs_byteenable[0]) begin
                            nxt_st.irq_status = st_ff.irq_status &
                                                ~wr_val[3:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
            // set wins over a write-one-to-clear in the same cycle
            nxt_st.irq_status = nxt_st.irq_status | irq_events;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            st_ff            <= '0;
            st_ff.mode       <= output_sync_pkg::MODE_MANAGER;
            st_ff.cycle_ns   <= output_sync_pkg::CYCLE_NS_RST;
            st_ff.min_period <= output_sync_pkg::MIN_PERIOD_RST;
            st_ff.command    <= output_sync_pkg::CMD_STOP;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign avs_readdata   = st_ff.rdata;
    assign apply_outputs  = st_ff.apply;
    assign measure_active = (st_ff.command == output_sync_pkg::CMD_START);
    assign irq            = |(st_ff.irq_status & st_ff.irq_mask);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic acc_wr;
    assign acc_wr = clk_en & avs_write & ~avs_waitrequest &
                    (avs_byteenable == 4'hF);

    chk_mode_write: assert property (
        acc_wr && avs_address == output_sync_pkg::OFS_MODE_SELECT
        |=> st_ff.mode == $past(avs_writedata[15:0]))
        else $error("mode write not stored");

    chk_cycle_write: assert property (
        acc_wr && avs_address == output_sync_pkg::OFS_CYCLE_NS
        |=> st_ff.cycle_ns == $past(avs_writedata))
        else $error("cycle period write not stored");

    chk_mask_read: assert property (
        clk_en && avs_read && avs_address == output_sync_pkg::OFS_SUPPORTED
        && avs_waitrequest |=> !avs_waitrequest &&
        avs_readdata == {16'h0000, output_sync_pkg::SUPPORTED_MASK})
        else $error("supported mask read wrong");

    chk_start_clear: assert property (
        start_meas |=> st_ff.pulse0_drv == 32'h0000_0000 &&
        st_ff.min_period == 32'h0000_0000 && measure_active)
        else $error("measurement start did not clear maxima");

    chk_period_max: assert property (
        clk_en && measure_active && outputs_done && st_ff.busy && !start_meas
        |=> st_ff.min_period >= $past(st_ff.since_start))
        else $error("measured period not kept as maximum");

    chk_overrun_count: assert property (
        clk_en && cycle_start && operational && st_ff.busy &&
        st_ff.overrun != output_sync_pkg::COUNT_MAX
        |=> st_ff.overrun == $past(st_ff.overrun) + 16'h0001)
        else $error("overrun not counted");

    chk_missed_hold: assert property (
        !operational || !dc_mode |=> st_ff.missed == $past(st_ff.missed))
        else $error("missed count moved outside operation");

    chk_late_flag: assert property (
        clk_en && cycle_start && dc_mode |=> st_ff.late == $past(st_ff.busy))
        else $error("late flag does not follow pending outputs");

    chk_count_sat: assert property (
        st_ff.overrun == output_sync_pkg::COUNT_MAX
        |=> st_ff.overrun == output_sync_pkg::COUNT_MAX)
        else $error("overrun counter wrapped");

    chk_bus_answer: assert property (
        clk_en && bus_req && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not given after one wait cycle");

    chk_gap_count: assert property (
        clk_en && edge1 && dc_mode && st_ff.since0 < st_ff.gap_min &&
        st_ff.gap_short != output_sync_pkg::COUNT_MAX
        |=> st_ff.gap_short == $past(st_ff.gap_short) + 16'h0001)
        else $error("short pulse gap not counted");

    chk_missed_count: assert property (
        clk_en && cycle_start && operational && dc_mode &&
        !st_ff.event_seen && !edge_ev &&
        st_ff.missed != output_sync_pkg::COUNT_MAX
        |=> st_ff.missed == $past(st_ff.missed) + 16'h0001)
        else $error("missed manager event not counted");

    // a clear written in the same cycle must not swallow a new event
    chk_status_sticky: assert property (
        irq_events != 4'h0 |=> (st_ff.irq_status & $past(irq_events)) ==
        $past(irq_events))
        else $error("status event lost");

    chk_entry_read: assert property (
        clk_en && avs_read && avs_waitrequest &&
        avs_address == output_sync_pkg::OFS_ENTRY_COUNT
        |=> avs_readdata == {24'h00_0000, output_sync_pkg::ENTRY_COUNT})
        else $error("entry count read wrong");

    cov_overrun: cover property (
        clk_en && cycle_start && operational && st_ff.busy);
    cov_measure: cover property (
        measure_active && outputs_done && dc_mode);
    cov_free_run: cover property (clk_en && timer_fire);
    cov_irq: cover property ($rose(irq));

endmodule // output_sync_params

// >>> verification/sync_master_model.sv
// far-side model: sync pulse generator and fieldbus master timing
`timescale 1ns/1ps
module sync_master_model (
    input  wire logic       clk_sys,       // system clock
    input  wire logic [2:0] fire,          // strobe: pulse0, pulse1, event
    input  wire logic [7:0] done_lag,      // clocks to outputs_done, 0 never
    input  wire logic       apply_outputs, // cycle start from the block
    output logic            pulse0_pin,    // pulse 0 pin
    output logic            pulse1_pin,    // pulse 1 pin
    output logic            manager_event, // manager event pin
    output logic            outputs_done   // outputs were driven
);
    logic [1:0] hold_ff [3];
    logic [7:0] lag_ff;
    initial begin
        hold_ff = '{2'h0, 2'h0, 2'h0};
        lag_ff = 8'h00;
        outputs_done = 1'b0;
    end
    // pins stay up three clocks so the two-flop synchroniser sees them
    always @(posedge clk_sys) begin
        for (int i = 0; i < 3; i++) begin
            if (fire[i]) hold_ff[i] <= 2'h3;
            else if (hold_ff[i] != 2'h0) hold_ff[i] <= hold_ff[i] - 2'h1;
        end
        // a zero lag never finishes: the slow master that forces overruns
        outputs_done <= (lag_ff == 8'h01);
        if (apply_outputs) lag_ff <= done_lag;
        else if (lag_ff != 8'h00) lag_ff <= lag_ff - 8'h01;
    end
    assign pulse0_pin    = (hold_ff[0] != 2'h0);
    assign pulse1_pin    = (hold_ff[1] != 2'h0);
    assign manager_event = (hold_ff[2] != 2'h0);
endmodule // sync_master_model

// >>> verification/output_sync_params_bench.sv
// self-checking bench for the output synchronisation parameter bank
`timescale 1ns/1ps
module output_sync_params_bench;
    logic        clk_sys, rst_n, clk_en, avs_read, avs_write, operational;
    logic        avs_waitrequest, apply_outputs, measure_active, irq;
    logic        pulse0_pin, pulse1_pin, manager_event, outputs_done;
    logic [7:0]  avs_address, done_lag;
    logic [31:0] avs_writedata, avs_readdata;
    logic [2:0]  fire;
    logic [3:0]  be_lanes;
    int          err_total, samples_checked;
    ////////////////////////////////////////////////////////////////////////
    output_sync_params DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(be_lanes), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .pulse0_pin(pulse0_pin),
        .pulse1_pin(pulse1_pin), .manager_event(manager_event),
        .operational(operational), .outputs_done(outputs_done),
        .apply_outputs(apply_outputs), .measure_active(measure_active),
        .irq(irq));
    sync_master_model far_side (.clk_sys(clk_sys), .fire(fire),
        .done_lag(done_lag), .apply_outputs(apply_outputs),
        .pulse0_pin(pulse0_pin), .pulse1_pin(pulse1_pin),
        .manager_event(manager_event), .outputs_done(outputs_done));
    ////////////////////////////////////////////////////////////////////////
    task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // request held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= !wr;
        avs_write     <= wr;
        @(posedge clk_sys iff avs_waitrequest === 1'b0);
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk_sys);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk32(q, exp);
    endtask
    task automatic pulse(input logic [2:0] f);
        fire <= f;
        @(posedge clk_sys);
        fire <= 3'h0;
        @(posedge clk_sys);
    endtask
    task automatic wait_apply(input int lim, output int k);
        k = 0;
        while (apply_outputs !== 1'b1 && k < lim) begin
            @(posedge clk_sys);
            k++;
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] exp [16];
        exp = '{default: 32'h0};
        exp[0] = 32'h0000_0020;
        exp[1] = 32'h0000_0001;
        exp[2] = 32'h0007_A120;
        exp[4] = 32'h0000_C007;
        exp[5] = 32'h0000_4E20;
        for (int i = 0; i < 16; i++)
            rd_chk(8'(4 * i), exp[i]);
    endtask
    task automatic t_access();
        wr(8'h04, 32'h0000_0003);
        rd_chk(8'h04, 32'h0000_0003);
        wr(8'h08, 32'h0000_4E20);
        rd_chk(8'h08, 32'h0000_4E20);
        // low lane only: the upper bytes must survive the write
        be_lanes <= 4'h1;
        wr(8'h08, 32'hFFFF_FF20);
        be_lanes <= 4'hF;
        rd_chk(8'h08, 32'h0000_4E20);
        wr(8'h10, 32'h0);
        rd_chk(8'h10, 32'h0000_C007);
        wr(8'h00, 32'h0);
        rd_chk(8'h00, 32'h0000_0020);
        wr(8'h28, 32'hFFFF_FFFF);
        rd_chk(8'h28, 32'h0);
        wr(8'h3C, 32'hFFFF_FFFF);
        rd_chk(8'h3C, 32'h0);
    endtask
    task automatic t_modes();
        int k;
        done_lag <= 8'h02;
        for (int m = 1; m < 4; m++) begin
            wr(8'h04, 32'(m));
            pulse(m == 1 ? 3'h4 : (m == 2 ? 3'h1 : 3'h2));
            wait_apply(12, k);
            chk1(k < 12, 1'b1);
            repeat (4) @(posedge clk_sys);
        end
        wr(8'h04, 32'h0);
        wait_apply(500, k);
        @(posedge clk_sys);
        wait_apply(500, k);
        chk32(32'(k + 1), 32'h0000_0190);
        wr(8'h04, 32'h0000_0002);
    endtask
    task automatic t_measure();
        logic [31:0] q;
        done_lag <= 8'h06;
        wr(8'h1C, 32'h0000_0001);
        chk1(measure_active, 1'b1);
        pulse(3'h1);
        repeat (20) @(posedge clk_sys);
        bus(1'b0, 8'h0C, 32'h0, q);
        chk1(q != 32'h0, 1'b1);
        bus(1'b0, 8'h14, 32'h0, q);
        chk1(q != 32'h0 && q < 32'h0000_03E8, 1'b1);
        wr(8'h1C, 32'h0);
        chk1(measure_active, 1'b0);
        wr(8'h1C, 32'h0000_0001);
        rd_chk(8'h0C, 32'h0);
    endtask
    task automatic t_faults();
        operational <= 1'b1;
        done_lag    <= 8'h00;
        // pin must fall between pulses or the two merge into one edge
        repeat (2) begin
            pulse(3'h1);
            repeat (4) @(posedge clk_sys);
        end
        repeat (8) @(posedge clk_sys);
        rd_chk(8'h24, 32'h0000_0002);
        rd_chk(8'h28, 32'h0000_0001);
        rd_chk(8'h30, 32'h0000_0001);
        rd_chk(8'h34, 32'h0000_000B);
        chk1(irq, 1'b0);
        done_lag <= 8'h02;
        pulse(3'h1);
        repeat (8) @(posedge clk_sys);
        pulse(3'h1);
        repeat (8) @(posedge clk_sys);
        rd_chk(8'h30, 32'h0);
        wr(8'h38, 32'h0000_000F);
        chk1(irq, 1'b1);
        wr(8'h34, 32'h0000_000F);
        chk1(irq, 1'b0);
        // long pair sets the required gap, a short pair then trips it
        pulse(3'h1);
        repeat (6) @(posedge clk_sys);
        pulse(3'h2);
        repeat (8) @(posedge clk_sys);
        pulse(3'h1);
        pulse(3'h2);
        repeat (8) @(posedge clk_sys);
        rd_chk(8'h2C, 32'h0000_0001);
        rd_chk(8'h18, 32'h0000_015E);
        rd_chk(8'h34, 32'h0000_0005);
        chk1(irq, 1'b1);
    endtask
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        if (err_total == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_total++;
        wrap_up();
    end
    initial begin
        {rst_n, avs_read, avs_write, operational} = 4'h0;
        clk_en = 1'b1;
        avs_address = 8'h00;
        avs_writedata = 32'h0;
        fire = 3'h0;
        be_lanes = 4'hF;
        done_lag = 8'h00;
        err_total = 0;
        samples_checked = 0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        t_reset();
        t_access();
        t_modes();
        t_measure();
        t_faults();
        wrap_up();
    end
endmodule // output_sync_params_bench
